//--- verilog/fra_pkg.sv
// Constants, layouts and types shared by the frequency reference adjust block
package fra_pkg;
    // Terminal function codes
    localparam logic [7:0] FN_RAMP_HOLD = 8'h0A;
    localparam logic [7:0] FN_UP = 8'h10;
    localparam logic [7:0] FN_DOWN = 8'h11;
    localparam logic [7:0] FN_TRIM_UP = 8'h1C;
    localparam logic [7:0] FN_TRIM_DN = 8'h1D;
    localparam logic [7:0] FN_SAMPLE_HOLD = 8'h1E;
    localparam int NUM_TERM = 10;
    // Register byte offsets; terminal selects sit at FSEL_BASE + 4*index
    localparam logic [7:0] FSEL_BASE = 8'h00;
    localparam logic [7:0] CONFIG_OFS = 8'h28;
    localparam logic [7:0] LIMIT_OFS = 8'h2C;
    localparam logic [7:0] TRIM_OFS = 8'h30;
    localparam logic [7:0] RATE_OFS = 8'h34;
    localparam logic [7:0] STATUS_OFS = 8'h38;
    localparam logic [7:0] FREQ_OFS = 8'h3C;
    // Field positions: low fields at bit 0, high fields at bit 16
    localparam int HI_POS = 16;
    localparam int CFG_RUN_POS = 0;
    localparam int CFG_ANA_POS = 2;
    localparam int CFG_HOLD_POS = 3;
    // Frequencies are 0.1 % steps of maximum output frequency
    localparam int FW = 12;
    localparam logic [FW-1:0] LIMIT_MAX = 12'h44C;
    localparam logic [FW-1:0] UL_RESET = 12'h3E8;
    localparam logic [FW-1:0] LL_RESET = 12'h000;
    localparam logic [FW-1:0] MLL_RESET = 12'h000;
    localparam logic [6:0] TRIM_MAX = 7'h64;
    localparam logic [6:0] TRIM_RESET = 7'h0A;
    localparam logic [FW-1:0] STEP_RESET = 12'h001;
    localparam logic [1:0] RUN_SRC_RESET = 2'h1;
    localparam logic [3:0] TENTHS = 4'hA;
    // Timing: one ramp tick per millisecond, sample delay in ticks
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int SH_MS = 100;
    localparam logic [7:0] SH_TICKS = 8'(SH_MS * 1000 / TICK_US);

    typedef struct packed {
        logic [FW-1:0] ul;
        logic [FW-1:0] ll;
        logic [FW-1:0] mll;
        logic [6:0] trim;
        logic [FW-1:0] acc;
        logic [FW-1:0] dec;
        logic [1:0] run_src;
        logic ref_analog;
        logic hold_mem;
    } cfg_type;

    typedef enum logic [2:0] {
        SH_IDLE = 3'b001,
        SH_WAIT = 3'b010,
        SH_HELD = 3'b100
    } sh_state_type;
endpackage : fra_pkg

//--- verilog/frequency_reference_adjust.sv
// Frequency reference adjust: up/down, trim, sample/hold and limits over AHB-Lite
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Function code 10 selects increase command, 11 selects decrease command.
// - Output frequency follows reference changes at the configured ramp rates.
// - Upper limit 0.0 to 110.0 percent, default 100.0, caps the reference.
// - Reference and master lower limits, percent of maximum, default 0.0.
// - Only one of increase or decrease assigned raises selection error.
// - Increase/decrease together with ramp hold raises selection error.
// - Lower limit is the larger of analog reference and lower-limit settings.
// - Run command with increase/decrease ramps output up to the lower limit.
// - Multi-step speed selection is disabled while increase/decrease is configured.
// - Hold memory 1 keeps reference over power loss and ramps to it.
// - Increase or decrease while running clears the stored reference to 0.
// - Function code 1C selects trim increase, 1D selects trim decrease.
// - Trim level 0 to 100 percent of maximum, default 10.
// - Trim up adds level, trim down subtracts, both or neither pass through.
// - Trim acts only for a positive reference from the analog input.
// - A trim result below zero gives a zero reference.
// - Only one trim command assigned raises selection error.
// - Code 1E samples analog reference 100 ms after input on, then holds.
// - Sample/hold with ramp hold, increase/decrease or trim raises error.
// - Sample/hold input shorter than 100 ms does not hold a reference.
// - Sampled reference is lost at power down.
module frequency_reference_adjust #(
    parameter int TICK_CYCLES = fra_pkg::TICK_CYC
) (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic reset, // Synchronous reset, high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    input wire logic [9:0] contact_in, // Contact input terminals, async
    input wire logic run_in, // Run command terminal, async
    input wire logic [11:0] analog_ref, // Analog terminal reference, 0.1 %
    input wire logic [11:0] nv_ref_in, // Retained reference from nonvolatile store
    output logic [11:0] out_freq, // Ramped output frequency, 0.1 %
    output logic [11:0] nv_ref_out, // Reference to keep in nonvolatile store
    output logic config_error, // Invalid input selection error
    output logic multistep_enable // Multi-step speed selection allowed
);
    // Terminal function-code match, used for every contact-terminal decode; run has its own pin
    function automatic logic [9:0] func_hit(input logic [9:0][7:0] sel, input logic [7:0] code);
        logic [9:0] m;
        m = '0;
        for (int i = 0; i < fra_pkg::NUM_TERM; i++)
            m[i] = (sel[i] == code);
        return m;
    endfunction : func_hit

    // Clamp a value into a window
    function automatic logic [11:0] clamp(input logic [11:0] v, input logic [11:0] lo,
        input logic [11:0] hi);
        logic [11:0] r;
        r = (v < lo) ? lo : v;
        r = (r > hi) ? hi : r;
        return r;
    endfunction : clamp

    // Two-flop synchronisers for pins
    logic [10:0] sync1_r, sync2_r;
    always_ff @(posedge ref_clk)
    begin
        sync1_r <= reset ? 11'h000 : {run_in, contact_in};
        sync2_r <= reset ? 11'h000 : sync1_r;
    end
    logic [9:0] contact_s;
    logic run_s;
    assign contact_s = sync2_r[9:0];
    assign run_s = sync2_r[10];

    // Millisecond tick divider
    logic [15:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    always_comb
    begin
        tick_nxt = (div_r == 16'(TICK_CYCLES - 1));
        div_nxt = tick_nxt ? 16'h0000 : div_r + 16'h0001;
    end
    always_ff @(posedge ref_clk)
    begin
        div_r <= reset ? 16'h0000 : div_nxt;
        tick_r <= reset ? 1'b0 : tick_nxt;
    end

    // AHB-Lite slave: registers address phase, always zero wait, OKAY
    logic [9:0][7:0] fsel_r, fsel_nxt;
    fra_pkg::cfg_type cfg_r, cfg_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] rdata_nxt;
    logic [31:0] status_w, freq_w;
    logic acc_ok;
    assign acc_ok = hsel && htrans[1] && hready;
    always_comb
    begin
        fsel_nxt = fsel_r;
        cfg_nxt = cfg_r;
        wr_pend_nxt = acc_ok && hwrite;
        wr_addr_nxt = acc_ok ? haddr[7:0] : wr_addr_r;
        rdata_nxt = 32'h00000000;
        // Writes land in the data phase; settings beyond range are clamped
        if (wr_pend_r)
        begin
            for (int i = 0; i < fra_pkg::NUM_TERM; i++)
                if (wr_addr_r == fra_pkg::FSEL_BASE + 8'(4 * i))
                    fsel_nxt[i] = hwdata[7:0];
            unique case (wr_addr_r)
                fra_pkg::CONFIG_OFS:
                begin
                    cfg_nxt.run_src = hwdata[fra_pkg::CFG_RUN_POS +: 2];
                    cfg_nxt.ref_analog = hwdata[fra_pkg::CFG_ANA_POS];
                    cfg_nxt.hold_mem = hwdata[fra_pkg::CFG_HOLD_POS];
                end
                fra_pkg::LIMIT_OFS:
                begin
                    cfg_nxt.ul = clamp(hwdata[11:0], 12'h000, fra_pkg::LIMIT_MAX);
                    cfg_nxt.ll = clamp(hwdata[fra_pkg::HI_POS +: 12], 12'h000,
                        fra_pkg::LIMIT_MAX);
                end
                fra_pkg::TRIM_OFS:
                begin
                    cfg_nxt.mll = clamp(hwdata[11:0], 12'h000, fra_pkg::LIMIT_MAX);
                    cfg_nxt.trim = (hwdata[fra_pkg::HI_POS +: 7] > fra_pkg::TRIM_MAX) ?
                        fra_pkg::TRIM_MAX : hwdata[fra_pkg::HI_POS +: 7];
                end
                fra_pkg::RATE_OFS:
                begin
                    cfg_nxt.acc = hwdata[11:0];
                    cfg_nxt.dec = hwdata[fra_pkg::HI_POS +: 12];
                end
                default:
                begin
                end
            endcase
        end
        // Read data is prepared in the address phase
        if (acc_ok && !hwrite)
        begin
            for (int i = 0; i < fra_pkg::NUM_TERM; i++)
                if (haddr[7:0] == fra_pkg::FSEL_BASE + 8'(4 * i))
                    rdata_nxt = {24'h000000, fsel_r[i]};
            unique case (haddr[7:0])
                fra_pkg::CONFIG_OFS:
                    rdata_nxt = {28'h0000000, cfg_r.hold_mem, cfg_r.ref_analog, cfg_r.run_src};
                fra_pkg::LIMIT_OFS:
                    rdata_nxt = {4'h0, cfg_r.ll, 4'h0, cfg_r.ul};
                fra_pkg::TRIM_OFS:
                    rdata_nxt = {9'h000, cfg_r.trim, 4'h0, cfg_r.mll};
                fra_pkg::RATE_OFS:
                    rdata_nxt = {4'h0, cfg_r.dec, 4'h0, cfg_r.acc};
                fra_pkg::STATUS_OFS:
                    rdata_nxt = status_w;
                fra_pkg::FREQ_OFS:
                    rdata_nxt = freq_w;
                default:
                begin
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            fsel_r <= '0;
            cfg_r <= '{ul: fra_pkg::UL_RESET, ll: fra_pkg::LL_RESET, mll: fra_pkg::MLL_RESET,
                trim: fra_pkg::TRIM_RESET, acc: fra_pkg::STEP_RESET, dec: fra_pkg::STEP_RESET,
                run_src: fra_pkg::RUN_SRC_RESET, ref_analog: 1'b1, hold_mem: 1'b0};
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            fsel_r <= fsel_nxt;
            cfg_r <= cfg_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata <= rdata_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Function assignment decode and selection checks
    logic has_up, has_dn, has_tu, has_td, has_sh, has_rh, err_c;
    logic up_cmd, dn_cmd, tu_cmd, td_cmd, sh_cmd;
    always_comb
    begin
        has_up = |func_hit(fsel_r, fra_pkg::FN_UP);
        has_dn = |func_hit(fsel_r, fra_pkg::FN_DOWN);
        has_tu = |func_hit(fsel_r, fra_pkg::FN_TRIM_UP);
        has_td = |func_hit(fsel_r, fra_pkg::FN_TRIM_DN);
        has_sh = |func_hit(fsel_r, fra_pkg::FN_SAMPLE_HOLD);
        has_rh = |func_hit(fsel_r, fra_pkg::FN_RAMP_HOLD);
        up_cmd = |(func_hit(fsel_r, fra_pkg::FN_UP) & contact_s);
        dn_cmd = |(func_hit(fsel_r, fra_pkg::FN_DOWN) & contact_s);
        tu_cmd = |(func_hit(fsel_r, fra_pkg::FN_TRIM_UP) & contact_s);
        td_cmd = |(func_hit(fsel_r, fra_pkg::FN_TRIM_DN) & contact_s);
        sh_cmd = |(func_hit(fsel_r, fra_pkg::FN_SAMPLE_HOLD) & contact_s);
        err_c = (has_up ^ has_dn)
            | ((has_up | has_dn) & has_rh)
            | (has_tu ^ has_td)
            | (has_sh & (has_rh | has_up | has_dn | has_tu | has_td));
    end

    // Sample/hold: analog value taken after the input has stood 100 ticks
    fra_pkg::sh_state_type sh_r, sh_nxt;
    logic [7:0] sh_cnt_r, sh_cnt_nxt;
    logic [11:0] sh_ref_r, sh_ref_nxt;
    always_comb
    begin
        sh_nxt = sh_r;
        sh_cnt_nxt = sh_cnt_r;
        sh_ref_nxt = sh_ref_r;
        unique case (sh_r)
            fra_pkg::SH_IDLE:
            begin
                sh_cnt_nxt = 8'h00;
                if (sh_cmd && !err_c)
                    sh_nxt = fra_pkg::SH_WAIT;
            end
            fra_pkg::SH_WAIT:
            begin
                if (!sh_cmd || err_c)
                    sh_nxt = fra_pkg::SH_IDLE;
                else if (tick_r && sh_cnt_r == fra_pkg::SH_TICKS - 8'h01)
                begin
                    sh_nxt = fra_pkg::SH_HELD;
                    sh_ref_nxt = analog_ref;
                end
                else if (tick_r)
                    sh_cnt_nxt = sh_cnt_r + 8'h01;
            end
            fra_pkg::SH_HELD:
            begin
                // A new press takes no fresh sample; the held value stays until 1E is unassigned or an error
                if (!has_sh || err_c)
                    sh_nxt = fra_pkg::SH_IDLE;
                else if (!sh_cmd)
                    sh_cnt_nxt = 8'h00;
                else if (sh_cnt_r == 8'h00 && tick_r)
                    sh_cnt_nxt = 8'h00;
            end
            default:
                sh_nxt = fra_pkg::SH_IDLE;
        endcase
    end
    // Held value is cleared by reset, so it never outlives power down
    always_ff @(posedge ref_clk)
    begin
        sh_r <= reset ? fra_pkg::SH_IDLE : sh_nxt;
        sh_cnt_r <= reset ? 8'h00 : sh_cnt_nxt;
        sh_ref_r <= reset ? 12'h000 : sh_ref_nxt;
    end

    // Up/down reference, power-up restore and output ramp
    logic ud_en, run_prev_r, boot_r, restored_r, restored_nxt, ud_edge_prev_r;
    logic [11:0] ud_ref_r, ud_ref_nxt, saved_r, saved_nxt, out_nxt, tgt_c, eff_ll, base_ll;
    logic [11:0] trim_amt, trimmed;
    logic err_nxt, ms_nxt;
    logic [11:0] nv_nxt;
    always_comb
    begin
        ud_en = has_up && has_dn && !err_c;
        base_ll = (cfg_r.ll > cfg_r.mll) ? cfg_r.ll : cfg_r.mll;
        eff_ll = (analog_ref > base_ll) ? analog_ref : base_ll;
        trim_amt = 12'(cfg_r.trim) * 12'(fra_pkg::TENTHS);
        saved_nxt = boot_r ? nv_ref_in : saved_r;
        restored_nxt = restored_r;
        ud_ref_nxt = ud_ref_r;
        if (run_s && !run_prev_r)
        begin
            // Run start: restored value only with hold memory set
            ud_ref_nxt = cfg_r.hold_mem ? saved_r : 12'h000;
            restored_nxt = cfg_r.hold_mem;
        end
        else if (run_s && restored_r && (up_cmd || dn_cmd) && !ud_edge_prev_r)
        begin
            ud_ref_nxt = 12'h000;
            restored_nxt = 1'b0;
        end
        else if (run_s && ud_en && tick_r)
        begin
            if (up_cmd && !dn_cmd)
                ud_ref_nxt = (ud_ref_r > cfg_r.ul - cfg_r.acc) ? cfg_r.ul : ud_ref_r + cfg_r.acc;
            else if (dn_cmd && !up_cmd)
                ud_ref_nxt = (ud_ref_r < cfg_r.dec) ? 12'h000 : ud_ref_r - cfg_r.dec;
            ud_ref_nxt = clamp(ud_ref_nxt, eff_ll, cfg_r.ul);
        end
        // Trim only on a positive analog reference, floored at zero
        trimmed = analog_ref;
        if (cfg_r.ref_analog && analog_ref != 12'h000 && (tu_cmd ^ td_cmd))
        begin
            if (tu_cmd)
                trimmed = analog_ref + trim_amt;
            else
                trimmed = (analog_ref < trim_amt) ? 12'h000 : analog_ref - trim_amt;
        end
        if (!run_s)
            tgt_c = 12'h000;
        else if (ud_en)
            tgt_c = clamp(ud_ref_r, eff_ll, cfg_r.ul);
        else if (sh_r == fra_pkg::SH_HELD)
            tgt_c = clamp(sh_ref_r, 12'h000, cfg_r.ul);
        else
            tgt_c = clamp(trimmed, 12'h000, cfg_r.ul);
        // Ramp: step toward the target once per tick, never jump
        out_nxt = out_freq;
        if (tick_r && out_freq < tgt_c)
            out_nxt = (tgt_c - out_freq > cfg_r.acc) ? out_freq + cfg_r.acc : tgt_c;
        else if (tick_r && out_freq > tgt_c)
            out_nxt = (out_freq - tgt_c > cfg_r.dec) ? out_freq - cfg_r.dec : tgt_c;
        err_nxt = err_c;
        ms_nxt = !(has_up && has_dn);
        nv_nxt = cfg_r.hold_mem ? ud_ref_r : 12'h000;
    end
    always_ff @(posedge ref_clk)
    begin
        boot_r <= reset;
        run_prev_r <= reset ? 1'b0 : run_s;
        ud_edge_prev_r <= reset ? 1'b0 : (up_cmd || dn_cmd);
        restored_r <= reset ? 1'b0 : restored_nxt;
        saved_r <= reset ? 12'h000 : saved_nxt;
        ud_ref_r <= reset ? 12'h000 : ud_ref_nxt;
        out_freq <= reset ? 12'h000 : out_nxt;
        config_error <= reset ? 1'b0 : err_nxt;
        multistep_enable <= reset ? 1'b1 : ms_nxt;
        nv_ref_out <= reset ? 12'h000 : nv_nxt;
    end

    // Read-only views of the block's own state
    assign status_w = {4'h0, tgt_c, 11'h000, restored_r, sh_r == fra_pkg::SH_HELD,
        ud_en, run_s, config_error};
    assign freq_w = {4'h0, ud_ref_r, 4'h0, out_freq};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_err_pair;
        (has_up != has_dn) |=> config_error;
    endproperty
    a_err_pair: assert property (p_err_pair) else $error("Unpaired up/down not flagged");
    property p_err_rh;
        (has_up && has_dn && has_rh) |=> config_error;
    endproperty
    a_err_rh: assert property (p_err_rh) else $error("Up/down with ramp hold not flagged");
    property p_err_trim;
        (has_tu != has_td) |=> config_error;
    endproperty
    a_err_trim: assert property (p_err_trim) else $error("Unpaired trim not flagged");
    property p_err_sh;
        (has_sh && (has_rh || has_up || has_dn || has_tu || has_td)) |=> config_error;
    endproperty
    a_err_sh: assert property (p_err_sh) else $error("Sample/hold conflict not flagged");
    property p_multistep;
        (has_up && has_dn) |=> !multistep_enable;
    endproperty
    a_multistep: assert property (p_multistep) else $error("Multi-step left enabled");
    property p_ramp;
        !tick_r |=> out_freq == $past(out_freq);
    endproperty
    a_ramp: assert property (p_ramp) else $error("Output moved off a tick");
    property p_cap;
        run_s |-> tgt_c <= cfg_r.ul;
    endproperty
    a_cap: assert property (p_cap) else $error("Target above upper limit");
    sequence s_sh_last;
        sh_r == fra_pkg::SH_WAIT && sh_cmd && !err_c && tick_r
            && sh_cnt_r == fra_pkg::SH_TICKS - 8'h01;
    endsequence
    property p_sh_take;
        s_sh_last |=> sh_r == fra_pkg::SH_HELD && sh_ref_r == $past(analog_ref);
    endproperty
    a_sh_take: assert property (p_sh_take) else $error("Sample not taken");
    property p_sh_short;
        (sh_r == fra_pkg::SH_WAIT && !sh_cmd) |=> sh_r == fra_pkg::SH_IDLE;
    endproperty
    a_sh_short: assert property (p_sh_short) else $error("Short press was held");
    property p_clear;
        (run_s && run_prev_r && restored_r && (up_cmd || dn_cmd) && !ud_edge_prev_r)
            |=> ud_ref_r == 12'h000 && !restored_r;
    endproperty
    a_clear: assert property (p_clear) else $error("Stored reference not cleared");
endmodule : frequency_reference_adjust

//--- dv/contact_source.sv
// Contact and run command source standing in for the machine controller
`timescale 1ns/1ps
module contact_source (
    input wire logic ref_clk, // Bench clock
    input wire logic slow, // Add three cycles of relay delay
    input wire logic [9:0] want_contacts, // Requested contact levels
    input wire logic want_run, // Requested run level
    output logic [9:0] contact_in, // Contact terminals to the block
    output logic run_in // Run terminal to the block
);
    logic [10:0] dly_r [3];
    // Relay delay line; levels only shift in time, so a slow source never reorders commands
    always @(posedge ref_clk)
    begin
        dly_r[0] <= {want_run, want_contacts};
        dly_r[1] <= dly_r[0];
        dly_r[2] <= dly_r[1];
    end
    // Run arrives only on this terminal, as terminal operation is selected
    assign {run_in, contact_in} = slow ? dly_r[2] : {want_run, want_contacts};
endmodule : contact_source

//--- dv/frequency_reference_adjust_test.sv
// Self-checking bench for the frequency reference adjust block
`timescale 1ns/1ps
module frequency_reference_adjust_test;
    typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} note_type;
    localparam int TICK = 10;
    // Codes of terminals 0..2 and the expected selection error
    localparam logic [24:0] ERR_TABLE [9] = '{
        {24'h100000, 1'b1},
        {24'h101100, 1'b0},
        {24'h10110A, 1'b1},
        {24'h1C0000, 1'b1},
        {24'h1C1D00, 1'b0},
        {24'h1C1D1E, 1'b1},
        {24'h1E0A00, 1'b1},
        {24'h1E0000, 1'b0},
        {24'h001100, 1'b1}};
    // Analog value, trim up, trim down, expected target
    localparam logic [25:0] TRIM_TABLE [6] = '{
        {12'h12C, 2'b10, 12'h190},
        {12'h12C, 2'b01, 12'h0C8},
        {12'h12C, 2'b11, 12'h12C},
        {12'h12C, 2'b00, 12'h12C},
        {12'h030, 2'b01, 12'h000},
        {12'h000, 2'b10, 12'h000}};
    note_type notes[$];
    note_type n;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, config_error, multistep_enable, run_in, rd_dp = 1'b0;
    logic [9:0] want_c = 10'h0, contact_in;
    logic want_run = 1'b0, slow = 1'b0;
    logic [11:0] analog_ref = 12'h0, nv_ref_in = 12'h0, out_freq, nv_ref_out;
    logic [11:0] last_f = 12'h0, step = 12'h1, ana, dif;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    frequency_reference_adjust #(.TICK_CYCLES(TICK)) dut (.ref_clk(ref_clk), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .contact_in(contact_in), .run_in(run_in), .analog_ref(analog_ref),
        .nv_ref_in(nv_ref_in), .out_freq(out_freq), .nv_ref_out(nv_ref_out),
        .config_error(config_error), .multistep_enable(multistep_enable));

    contact_source partner (.ref_clk(ref_clk), .slow(slow), .want_contacts(want_c),
        .want_run(want_run), .contact_in(contact_in), .run_in(run_in));

    task automatic conclude;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One single-word transfer; a read leaves its expected value as a note
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic [31:0] mask);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        if (!w)
            notes.push_back('{$sformatf("reg %h", a), exp & mask, mask});
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0);
    endtask : wr

    task automatic set_fn(input logic [23:0] c);
        wr(8'h00, {24'h0, c[23:16]});
        wr(8'h04, {24'h0, c[15:8]});
        wr(8'h08, {24'h0, c[7:0]});
        // The selection error is registered one cycle after the last select lands
        @(posedge ref_clk);
    endtask : set_fn

    task automatic ticks(input int k);
        repeat (k * TICK) @(posedge ref_clk);
    endtask : ticks

    // Bounded wait for the ramp to settle, then compare
    task automatic wait_freq(input logic [11:0] t);
        int k;
        k = 0;
        while (out_freq !== t && k < 6000)
        begin
            @(posedge ref_clk);
            k++;
        end
        check("out_freq", {20'h0, t}, {20'h0, out_freq});
    endtask : wait_freq

    // Read data and ramp watcher; a step above the rate means the output jumped
    always @(posedge ref_clk)
    begin
        cycles++;
        if (rd_dp && hreadyout === 1'b1)
        begin
            n = notes.pop_front();
            check(n.name, n.exp, hrdata & n.mask);
        end
        rd_dp = hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
        dif = (out_freq > last_f) ? out_freq - last_f : last_f - out_freq;
        if (!reset && out_freq !== last_f)
            check("ramp step", 32'h1, {31'h0, dif <= step});
        last_f = out_freq;
        if (cycles == 30000)
        begin
            bad_count++;
            conclude();
        end
    end

    initial
    begin
        void'($urandom(32'hDE12));
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        bus(1'b0, fra_pkg::LIMIT_OFS, 32'h0, 32'h000003E8, 32'h0FFF0FFF);
        bus(1'b0, fra_pkg::TRIM_OFS, 32'h0, 32'h000A0000, 32'h007F0FFF);
        bus(1'b0, 8'h80, 32'h0, 32'h0, 32'hFFFFFFFF);
        wr(fra_pkg::LIMIT_OFS, 32'h00000FFF);
        bus(1'b0, fra_pkg::LIMIT_OFS, 32'h0, 32'h0000044C, 32'h0FFF0FFF);
        for (int i = 0; i < 9; i++)
        begin
            set_fn(ERR_TABLE[i][24:1]);
            bus(1'b0, fra_pkg::STATUS_OFS, 32'h0, {31'h0, ERR_TABLE[i][0]}, 32'h1);
            check("config_error", {31'h0, ERR_TABLE[i][0]}, {31'h0, config_error});
            check("multistep", {31'h0, ERR_TABLE[i][24:9] != 16'h1011}, {31'h0, multistep_enable});
        end
        // Increase/decrease with both lower limits and the upper limit
        set_fn(24'h101100);
        step <= 12'h8;
        wr(fra_pkg::CONFIG_OFS, 32'h5);
        wr(fra_pkg::RATE_OFS, 32'h00080008);
        wr(fra_pkg::LIMIT_OFS, 32'h0050012C);
        wr(fra_pkg::TRIM_OFS, 32'h000A0060);
        analog_ref <= 12'h020;
        want_run <= 1'b1;
        wait_freq(12'h060);
        ana = 12'h0C8 + 12'($urandom_range(63));
        analog_ref <= ana;
        wait_freq(ana);
        want_c <= 10'h001;
        wait_freq(12'h12C);
        want_c <= 10'h003;
        ticks(3);
        bus(1'b0, fra_pkg::FREQ_OFS, 32'h0, 32'h012C012C, 32'h0FFF0FFF);
        ticks(20);
        bus(1'b0, fra_pkg::FREQ_OFS, 32'h0, 32'h012C012C, 32'h0FFF0FFF);
        want_c <= 10'h002;
        wait_freq(ana);
        want_c <= 10'h000;
        want_run <= 1'b0;
        wait_freq(12'h000);
        // Retained reference across a power cycle, cleared by a command while running
        step <= 12'h1;
        nv_ref_in <= 12'h0F0;
        analog_ref <= 12'h040;
        reset <= 1'b1;
        ticks(1);
        reset <= 1'b0;
        @(posedge ref_clk);
        set_fn(24'h101100);
        wr(fra_pkg::CONFIG_OFS, 32'hD);
        want_run <= 1'b1;
        wait_freq(12'h0F0);
        check("nv_ref_out", 32'h0F0, {20'h0, nv_ref_out});
        want_c <= 10'h003;
        wait_freq(12'h040);
        // Trim with a slow contact source
        slow <= 1'b1;
        want_c <= 10'h000;
        set_fn(24'h1C1D00);
        for (int i = 0; i < 6; i++)
        begin
            analog_ref <= TRIM_TABLE[i][25:14];
            want_c <= {8'h0, TRIM_TABLE[i][12], TRIM_TABLE[i][13]};
            ticks(3);
            bus(1'b0, fra_pkg::STATUS_OFS, 32'h0, {4'h0, TRIM_TABLE[i][11:0], 16'h0}, 32'h0FFF0000);
        end
        // Sample/hold: a short pulse holds nothing, a long one holds the sampled value
        want_c <= 10'h000;
        set_fn(24'h1E0000);
        analog_ref <= 12'h0A0;
        want_c <= 10'h001;
        ticks(50);
        want_c <= 10'h000;
        ticks(2);
        bus(1'b0, fra_pkg::STATUS_OFS, 32'h0, 32'h0, 32'h8);
        want_c <= 10'h001;
        ticks(105);
        analog_ref <= 12'h200;
        ticks(2);
        bus(1'b0, fra_pkg::STATUS_OFS, 32'h0, 32'h00A00008, 32'h0FFF0008);
        reset <= 1'b1;
        ticks(1);
        reset <= 1'b0;
        @(posedge ref_clk);
        set_fn(24'h1E0000);
        ticks(10);
        bus(1'b0, fra_pkg::STATUS_OFS, 32'h0, 32'h0, 32'h8);
        ticks(1);
        conclude();
    end
endmodule : frequency_reference_adjust_test
